// [core/aid_regs.svh]
`ifndef AID_REGS_SVH
`define AID_REGS_SVH
// ----------------------------------------------------------------
// device register map (7-bit register address)
// ----------------------------------------------------------------
`define AID_A_PART_LO 7'h04
`define AID_A_PART_HI 7'h05
`define AID_A_HW_REV 7'h06
`define AID_A_TEST 7'h0A
`define AID_A_MAKER_LO 7'h0C
`define AID_A_MAKER_HI 7'h0D
`define AID_A_REPEAT 7'h0E
`define AID_A_XFER 7'h0F
`define AID_A_LINK_C 7'h10
`define AID_A_FLAGS 7'h11
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define AID_RST_TEST 8'h00
`define AID_RST_REPEAT 8'h00
`define AID_RST_XFER 8'h00
`define AID_RST_LINK_C 8'h13
`define AID_RST_FLAGS 8'h00
`define AID_XFER_HOLD_BIT 2
`define AID_LC_EN_HI 7
`define AID_LC_EN_LO 6
`define AID_LC_STRICT_BIT 5
`define AID_LC_STATUS_BIT 4
`define AID_LC_INV_HI 1
`define AID_LC_INV_LO 0
`define AID_LC_EN_ON 2'h1
`define AID_LC_INV_ON 2'h2
`define AID_LC_RW_MASK 8'hF3
`define AID_FL_ADDR_BIT 0
`define AID_FL_WRINV_BIT 2
`define AID_FL_CHK_BIT 3
`define AID_FL_MASK 8'h0D
`define AID_CHK_POLY 8'h07
// ----------------------------------------------------------------
// host controller software registers (8-bit port address)
// ----------------------------------------------------------------
`define AID_H_ADDR 8'h00
`define AID_H_WDATA 8'h01
`define AID_H_GO 8'h02
`define AID_H_STATUS 8'h03
`define AID_H_RDATA 8'h04
`define AID_H_IRQ_STAT 8'h05
`define AID_H_IRQ_MASK 8'h06
`define AID_H_IRQ_DONE_BIT 0
`define AID_H_IRQ_FIX_BIT 1
`define AID_H_GO_BAD_BIT 1
`endif

// [core/aid_pkg.sv]
`default_nettype none
`include "aid_regs.svh"
package aid_pkg;
  typedef logic [6:0] aid_addr_t;
  typedef logic [7:0] aid_byte_t;
  // gray path idle -> send -> wait, both bits flip on wait -> idle
  typedef enum logic [1:0] {
    AID_IDLE = 2'b00,
    AID_SEND = 2'b01,
    AID_WAIT = 2'b11
  } aid_state_e;
  // crc-8 over write flag, address and data, msb first
  function automatic aid_byte_t aid_chk(input logic wr, input aid_addr_t addr, input aid_byte_t data);
    logic [15:0] msg;
    aid_byte_t c;
    msg = {wr, addr, data};
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ msg[i]) begin
        c = {c[6:0], 1'b0} ^ `AID_CHK_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// [core/aid_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface aid_if;
  logic req;
  logic wr;
  aid_pkg::aid_addr_t addr;
  aid_pkg::aid_byte_t wdata;
  aid_pkg::aid_byte_t chk;
  logic ack;
  aid_pkg::aid_byte_t rdata;
  modport dev (input req, input wr, input addr, input wdata, input chk, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, output chk, input ack, input rdata);
endinterface
`default_nettype wire

// [core/aid_dev.sv]
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "aid_regs.svh"
// How it works
// RULE_01: part code low byte, read only
// RULE_02: part code high byte at next address
// RULE_03: revision in low nibble, upper nibble reserved
// RULE_04: test register returns last written value
// RULE_05: maker code bytes, read only, fixed
// RULE_06: host writes repeat count zero only
// RULE_07: host keeps transfer bit 2 zero
// RULE_08: checksum on only with enable 1, inverse 2
// RULE_09: enable resets 0, inverse resets 3
// RULE_10: host keeps bit4 one, bit5 zero
// RULE_11: status holds active-high transaction error flags
// RULE_12: flag clears only on written one
// RULE_13: bad checksum sets flag while enabled
// RULE_14: undefined address sets invalid-address flag
// RULE_15: reserved bits read fixed, ignore writes
module aid_dev #(
  parameter logic [15:0] PART_CODE = 16'h1A2B, // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h3C4D, // arbitrary value
  parameter logic [3:0] HW_REV = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // link to host
  aid_if.dev link,
  // user side
  output logic chk_on_o,
  output logic [7:0] test_val_o,
  output logic [7:0] err_flags_o,
  output logic err_o
);
  import aid_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  aid_byte_t test_q;
  aid_byte_t repeat_q;
  logic hold_length_bit_q;
  aid_byte_t link_c_q;
  aid_byte_t flags_q;
  aid_byte_t flags_d;
  aid_byte_t rdata_q;
  logic ack_q;
  logic chk_on_q;
  logic err_q;

  // ----------------------------------------------------------------
  // fixed identity bytes
  // ----------------------------------------------------------------
  wire aid_byte_t part_lo;
  wire aid_byte_t part_hi;
  wire aid_byte_t rev_byte;
  wire aid_byte_t maker_lo;
  wire aid_byte_t maker_hi;

  assign part_lo = PART_CODE[7:0]; // RULE_01
  assign part_hi = PART_CODE[15:8]; // RULE_02
  // upper nibble is reserved and reads as zero
  assign rev_byte = {4'h0, HW_REV}; // RULE_03
  assign maker_lo = MAKER_CODE[7:0]; // RULE_05
  assign maker_hi = MAKER_CODE[15:8]; // RULE_05

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // a write to any of these raises the read-only flag and changes nothing
  function automatic logic is_ro(input aid_addr_t a);
    return (a == `AID_A_PART_LO) || (a == `AID_A_PART_HI) || (a == `AID_A_HW_REV) ||
           (a == `AID_A_MAKER_LO) || (a == `AID_A_MAKER_HI);
  endfunction

  function automatic logic is_rw(input aid_addr_t a);
    return (a == `AID_A_TEST) || (a == `AID_A_REPEAT) || (a == `AID_A_XFER) ||
           (a == `AID_A_LINK_C) || (a == `AID_A_FLAGS);
  endfunction

  wire logic chk_on;
  wire logic chk_bad;
  wire logic known;
  wire logic take;
  wire logic wr_ok;
  wire logic wr_ro;
  wire logic addr_err;
  aid_byte_t rd_mux;
  wire aid_byte_t flag_set;
  wire aid_byte_t flag_clr;
  wire logic rd_ok;
  wire logic wr_test;
  wire logic wr_repeat;
  wire logic wr_xfer;
  wire logic wr_link_c;
  wire logic wr_flags;

  assign chk_on = (link_c_q[`AID_LC_EN_HI:`AID_LC_EN_LO] == `AID_LC_EN_ON) &&
                  (link_c_q[`AID_LC_INV_HI:`AID_LC_INV_LO] == `AID_LC_INV_ON); // RULE_08
  // a transfer that fails its checksum is dropped whole, so a corrupt write never lands
  assign chk_bad = chk_on && link.req && (link.chk != aid_chk(link.wr, link.addr, link.wdata)); // RULE_13
  assign known = is_ro(link.addr) || is_rw(link.addr);
  assign take = link.req && !chk_bad;
  assign addr_err = take && !known; // RULE_14
  assign wr_ro = take && link.wr && is_ro(link.addr);
  assign wr_ok = take && link.wr && is_rw(link.addr);
  assign rd_ok = take && !link.wr;

  // one enable per writable register keeps the write process free of address compares
  assign wr_test = wr_ok && (link.addr == `AID_A_TEST); // RULE_04
  assign wr_repeat = wr_ok && (link.addr == `AID_A_REPEAT);
  assign wr_xfer = wr_ok && (link.addr == `AID_A_XFER);
  assign wr_link_c = wr_ok && (link.addr == `AID_A_LINK_C);
  assign wr_flags = wr_ok && (link.addr == `AID_A_FLAGS); // RULE_12

  // bits 1 and 4 to 7 have no cause in this block and stay zero
  assign flag_set = {4'h0, chk_bad, wr_ro, 1'b0, addr_err}; // RULE_11
  assign flag_clr = wr_flags ? (link.wdata & `AID_FL_MASK) : 8'h00; // RULE_12

  // a new error in the clearing cycle survives the clear
  always_comb begin
    flags_d = (flags_q & ~flag_clr) | flag_set; // RULE_12
  end

  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  always_comb begin
    if (link.addr == `AID_A_PART_LO) begin
      rd_mux = part_lo; // RULE_01
    end else if (link.addr == `AID_A_PART_HI) begin
      rd_mux = part_hi; // RULE_02
    end else if (link.addr == `AID_A_HW_REV) begin
      rd_mux = rev_byte; // RULE_03
    end else if (link.addr == `AID_A_TEST) begin
      rd_mux = test_q; // RULE_04
    end else if (link.addr == `AID_A_MAKER_LO) begin
      rd_mux = maker_lo; // RULE_05
    end else if (link.addr == `AID_A_MAKER_HI) begin
      rd_mux = maker_hi; // RULE_05
    end else if (link.addr == `AID_A_REPEAT) begin
      rd_mux = repeat_q;
    end else if (link.addr == `AID_A_XFER) begin
      rd_mux = {5'h00, hold_length_bit_q, 2'h0}; // RULE_15
    end else if (link.addr == `AID_A_LINK_C) begin
      rd_mux = link_c_q;
    end else if (link.addr == `AID_A_FLAGS) begin
      rd_mux = flags_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      test_q <= `AID_RST_TEST;
      repeat_q <= `AID_RST_REPEAT; // RULE_06
      hold_length_bit_q <= 1'b0;
      link_c_q <= `AID_RST_LINK_C; // RULE_09
    end else begin
      if (wr_test) begin
        test_q <= link.wdata; // RULE_04
      end
      if (wr_repeat) begin
        repeat_q <= link.wdata;
      end
      if (wr_xfer) begin
        hold_length_bit_q <= link.wdata[`AID_XFER_HOLD_BIT]; // RULE_15
      end
      if (wr_link_c) begin
        link_c_q <= link.wdata & `AID_LC_RW_MASK; // RULE_15
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flags_q <= `AID_RST_FLAGS;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // every request is answered, refused ones too, so the host never waits forever
      ack_q <= link.req;
      rdata_q <= rd_ok ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // flopped so user logic never sees a decode glitch; chk_on_o lags the setup register by one cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chk_on_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      chk_on_q <= chk_on; // RULE_08
      err_q <= |flags_d; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign chk_on_o = chk_on_q;
  assign test_val_o = test_q;
  assign err_flags_o = flags_q;
  assign err_o = err_q;
endmodule
`default_nettype wire

// [core/aid_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "aid_regs.svh"
module aid_host (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // software port
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic irq_o,
  // link to device
  aid_if.host link
);
  import aid_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  aid_state_e state_q;
  aid_state_e state_d;
  aid_addr_t addr_q;
  aid_byte_t wdata_q;
  logic wr_q;
  logic bad_q;
  aid_byte_t rdata_q;
  aid_byte_t swr_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  wire logic go;
  wire logic done;
  wire logic fixed;
  aid_byte_t safe;

  assign go = sw_wr_i && (sw_addr_i == `AID_H_GO) && (state_q == AID_IDLE);
  assign done = (state_q == AID_WAIT) && link.ack;

  // reserved fields are forced to their required values before they leave
  always_comb begin
    safe = wdata_q;
    if (addr_q == `AID_A_REPEAT) begin
      safe = 8'h00; // RULE_06
    end else if (addr_q == `AID_A_XFER) begin
      safe[`AID_XFER_HOLD_BIT] = 1'b0; // RULE_07
    end else if (addr_q == `AID_A_LINK_C) begin
      safe[`AID_LC_STATUS_BIT] = 1'b1; // RULE_10
      safe[`AID_LC_STRICT_BIT] = 1'b0; // RULE_10
    end
  end
  assign fixed = (state_q == AID_SEND) && wr_q && (safe != wdata_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      AID_IDLE: begin
        if (go) begin
          state_d = AID_SEND;
        end
      end
      AID_SEND: begin
        state_d = AID_WAIT;
      end
      AID_WAIT: begin
        if (link.ack) begin
          state_d = AID_IDLE;
        end
      end
      default: begin
        state_d = AID_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= AID_IDLE;
      addr_q <= 7'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      bad_q <= 1'b0;
      rdata_q <= 8'h00;
      irq_mask_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (sw_wr_i && (sw_addr_i == `AID_H_ADDR) && (state_q == AID_IDLE)) begin
        addr_q <= sw_wdata_i[6:0];
      end
      if (sw_wr_i && (sw_addr_i == `AID_H_WDATA) && (state_q == AID_IDLE)) begin
        wdata_q <= sw_wdata_i;
      end
      if (go) begin
        wr_q <= sw_wdata_i[0];
        bad_q <= sw_wdata_i[`AID_H_GO_BAD_BIT];
      end
      if (sw_wr_i && (sw_addr_i == `AID_H_IRQ_MASK)) begin
        irq_mask_q <= sw_wdata_i[1:0];
      end
      if (done) begin
        rdata_q <= link.rdata;
      end
    end
  end

  // event wins over a same-cycle clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((sw_wr_i && (sw_addr_i == `AID_H_IRQ_STAT)) ? sw_wdata_i[1:0] : 2'h0))
                    | {fixed, done};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      swr_q <= 8'h00;
    end else if (!sw_rd_i) begin
      swr_q <= 8'h00;
    end else if (sw_addr_i == `AID_H_ADDR) begin
      swr_q <= {1'b0, addr_q};
    end else if (sw_addr_i == `AID_H_WDATA) begin
      swr_q <= wdata_q;
    end else if (sw_addr_i == `AID_H_STATUS) begin
      swr_q <= {7'h00, state_q != AID_IDLE};
    end else if (sw_addr_i == `AID_H_RDATA) begin
      swr_q <= rdata_q;
    end else if (sw_addr_i == `AID_H_IRQ_STAT) begin
      swr_q <= {6'h00, irq_stat_q};
    end else if (sw_addr_i == `AID_H_IRQ_MASK) begin
      swr_q <= {6'h00, irq_mask_q};
    end else begin
      swr_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sw_rdata_o = swr_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign link.req = (state_q == AID_SEND);
  assign link.wr = wr_q;
  assign link.addr = addr_q;
  assign link.wdata = safe; // RULE_08
  // a go with the fault bit set sends a wrong checksum, so software can prove the device refuses it
  assign link.chk = aid_chk(wr_q, addr_q, safe) ^ {7'h00, bad_q}; // RULE_13
endmodule
`default_nettype wire

// [dv/aid_link_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module aid_link_asserts #(
  parameter logic [15:0] PART_CODE = 16'h0000,
  parameter logic [15:0] MAKER_CODE = 16'h0000,
  parameter logic [3:0] HW_REV = 4'h0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire aid_pkg::aid_addr_t addr,
  input wire aid_pkg::aid_byte_t wdata,
  input wire aid_pkg::aid_byte_t chk,
  input wire logic ack,
  input wire aid_pkg::aid_byte_t rdata
);
  import aid_pkg::*;
  wire rd = req && !wr;
  wire wt = req && wr;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_later: assert property (req |=> ack) else $error("no ack after request");
  a_ack_has_cause: assert property (ack |-> $past(req)) else $error("ack without request");
  a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  a_req_spacing: assert property (req |=> !req) else $error("request before ack");
  a_part_low: assert property (rd && addr == 7'h04 |=> rdata == PART_CODE[7:0]) else $error("part low");
  a_part_high: assert property (rd && addr == 7'h05 |=> rdata == PART_CODE[15:8]) else $error("part high");
  a_rev_nibble: assert property (rd && addr == 7'h06 |=> rdata == {4'h0, HW_REV}) else $error("revision");
  a_maker_low: assert property (rd && addr == 7'h0C |=> rdata == MAKER_CODE[7:0]) else $error("maker low");
  a_maker_high: assert property (rd && addr == 7'h0D |=> rdata == MAKER_CODE[15:8]) else $error("maker high");
  a_bad_addr: assert property (rd && !(addr inside {7'h04, 7'h05, 7'h06, 7'h0A, [7'h0C:7'h11]}) |=>
    rdata == 8'h00) else $error("bad addr");
  a_write_no_data: assert property (wt |=> rdata == 8'h00) else $error("data on write");
  a_repeat_zero: assert property (wt && addr == 7'h0E |-> wdata == 8'h00) else $error("repeat not zero");
  a_xfer_bit: assert property (wt && addr == 7'h0F |-> !wdata[2]) else $error("transfer bit set");
  a_link_fixed: assert property (wt && addr == 7'h10 |-> wdata[5:4] == 2'b01) else $error("link bits");
  cover property (wt && addr == 7'h10 && wdata[7:6] == 2'h1 && wdata[1:0] == 2'h2);
  cover property (rd && addr == 7'h11);
  cover property (wt && addr == 7'h0A);
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "aid_regs.svh"
module tb_top;
  import aid_pkg::*;
  localparam logic [15:0] PC = 16'h1A2B; // arbitrary value
  localparam logic [15:0] MC = 16'h3C4D; // arbitrary value
  localparam logic [3:0] HR = 4'h1; // arbitrary value
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sa = 8'h00, sd = 8'h00, srd, tv, fl, tval;
  logic sw = 1'b0, sr = 1'b0, rd_d = 1'b0, irq, con, err;
  int error_cnt = 0, tests_run = 0;
  aid_byte_t exp_q[$];
  always #5 mclk_i = ~mclk_i;
  aid_if link_if();
  aid_host i_aid_host(.mclk_i(mclk_i), .rst_i(rst_i), .sw_addr_i(sa), .sw_wdata_i(sd), .sw_wr_i(sw),
    .sw_rd_i(sr), .sw_rdata_o(srd), .irq_o(irq), .link(link_if));
  aid_dev #(.PART_CODE(PC), .MAKER_CODE(MC), .HW_REV(HR)) i_aid_dev(.mclk_i(mclk_i), .rst_i(rst_i),
    .link(link_if), .chk_on_o(con), .test_val_o(tval), .err_flags_o(fl), .err_o(err));
  aid_link_asserts #(.PART_CODE(PC), .MAKER_CODE(MC), .HW_REV(HR)) i_aid_link_asserts(.mclk_i(mclk_i),
    .rst_i(rst_i), .req(link_if.req), .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata),
    .chk(link_if.chk), .ack(link_if.ack), .rdata(link_if.rdata));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge mclk_i) begin
    rd_d <= sr;
    if (rd_d) begin
      if (exp_q.size() == 0) error_cnt++;
      else cmp(srd, exp_q.pop_front());
    end
  end
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sa <= a;
    sd <= d;
    sw <= 1'b1;
    @(posedge mclk_i);
    sw <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge mclk_i);
    sa <= a;
    sr <= 1'b1;
    @(posedge mclk_i);
    sr <= 1'b0;
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 30) begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 30) error_cnt++;
  endtask
  task automatic dev_op(input logic w, input logic [6:0] a, input logic [7:0] d);
    sw_write(`AID_H_ADDR, {1'b0, a});
    sw_write(`AID_H_WDATA, d);
    sw_write(`AID_H_GO, {7'h00, w});
    wait_irq();
    sw_write(`AID_H_IRQ_STAT, 8'h03);
  endtask
  task automatic dev_rd(input logic [6:0] a, input logic [7:0] exp);
    dev_op(1'b0, a, 8'h00);
    sw_read(`AID_H_RDATA, exp);
  endtask
  initial begin
    void'($urandom(48));
    tv = 8'($urandom);
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    sw_read(`AID_H_IRQ_STAT, 8'h00);
    sw_write(`AID_H_IRQ_MASK, 8'h03);
    dev_rd(7'h10, 8'h13);
    cmp({7'h00, con}, 8'h00);
    dev_rd(7'h11, 8'h00);
    dev_rd(7'h04, PC[7:0]);
    dev_rd(7'h05, PC[15:8]);
    dev_rd(7'h06, {4'h0, HR});
    dev_rd(7'h0C, MC[7:0]);
    dev_rd(7'h0D, MC[15:8]);
    dev_op(1'b1, 7'h0A, tv);
    dev_rd(7'h0A, tv);
    cmp(tval, tv);
    cmp(fl, 8'h00);
    dev_op(1'b1, 7'h04, ~tv);
    dev_rd(7'h04, PC[7:0]);
    cmp(fl, 8'h04);
    dev_op(1'b1, 7'h11, 8'h00);
    cmp(fl, 8'h04);
    dev_op(1'b1, 7'h11, 8'h04);
    cmp(fl, 8'h00);
    dev_rd(7'h07, 8'h00);
    cmp(fl, 8'h01);
    cmp({7'h00, err}, 8'h01);
    dev_op(1'b1, 7'h11, 8'h01);
    dev_op(1'b1, 7'h7F, tv);
    cmp(fl, 8'h01);
    dev_op(1'b1, 7'h11, 8'h01);
    cmp({7'h00, err}, 8'h00);
    dev_op(1'b1, 7'h0E, 8'hFF);
    dev_rd(7'h0E, 8'h00);
    dev_op(1'b1, 7'h0F, 8'hFF);
    dev_rd(7'h0F, 8'h00);
    dev_op(1'b1, 7'h10, 8'h4F);
    cmp({7'h00, con}, 8'h00);
    dev_rd(7'h10, 8'h53);
    dev_op(1'b1, 7'h10, 8'h42);
    dev_rd(7'h10, 8'h52);
    cmp({7'h00, con}, 8'h01);
    dev_rd(7'h0A, tv);
    cmp(fl, 8'h00);
    // write with a corrupted checksum while protection is on
    sw_write(`AID_H_ADDR, 8'h0A);
    sw_write(`AID_H_WDATA, ~tv);
    sw_write(`AID_H_GO, 8'h03);
    wait_irq();
    sw_write(`AID_H_IRQ_STAT, 8'h03);
    cmp(fl, 8'h08);
    cmp(tval, tv);
    dev_op(1'b1, 7'h11, 8'h08);
    cmp(fl, 8'h00);
    // interrupt masking while a done event is pending
    sw_write(`AID_H_GO, 8'h00);
    wait_irq();
    sw_read(`AID_H_IRQ_STAT, 8'h01);
    sw_read(`AID_H_IRQ_MASK, 8'h03);
    sw_write(`AID_H_IRQ_MASK, 8'h00);
    #1 cmp({7'h00, irq}, 8'h00);
    sw_write(`AID_H_IRQ_MASK, 8'h03);
    #1 cmp({7'h00, irq}, 8'h01);
    sw_write(`AID_H_IRQ_STAT, 8'h03);
    #1 cmp({7'h00, irq}, 8'h00);
    dev_op(1'b1, 7'h10, 8'h13);
    cmp({7'h00, con}, 8'h00);
    dev_op(1'b1, 7'h10, 8'h42);
    cmp({7'h00, con}, 8'h01);
    // a second reset in mid-run must bring the registers back to their reset values
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    cmp({7'h00, con}, 8'h00);
    cmp(tval, 8'h00);
    cmp(fl, 8'h00);
    sw_write(`AID_H_IRQ_MASK, 8'h03);
    dev_rd(7'h10, 8'h13);
    repeat (4) @(posedge mclk_i);
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
